// ===== design/aifs_defines.svh
`ifndef AIFS_DEFINES_SVH
`define AIFS_DEFINES_SVH

// Number of input channels.
`define AIFS_CHANS 6

// Module fault summary word bit positions.
`define AIFS_MF_ANALOG 15
`define AIFS_MF_INPUT 14
`define AIFS_MF_CALBUSY 12
`define AIFS_MF_CALFAULT 11

// Per-channel status word bit positions.
`define AIFS_SB_CAL 7
`define AIFS_SB_BELOW 6
`define AIFS_SB_ABOVE 5
`define AIFS_SB_SLOPE 4
`define AIFS_SB_LO 3
`define AIFS_SB_HI 2
`define AIFS_SB_LL 1
`define AIFS_SB_HH 0

// Shared range status word: channel 0 bit positions, two bits per channel.
`define AIFS_IR_BELOW_TOP 15
`define AIFS_IR_ABOVE_TOP 14

// Forced channel fault word values and reset values.
`define AIFS_CF_CALBUSY 16'h003F
`define AIFS_CF_COMM 16'hFFFF
`define AIFS_WORD_RST 16'h0000
`define AIFS_STAT_RST 8'h00

`endif

// ===== design/aifs_pkg.sv
package aifs_pkg;

	// One signed channel sample.
	typedef logic signed [15:0] aifs_sample_t;

	// A produced 16-bit word.
	typedef logic [15:0] aifs_word_t;

	// One per-channel status word.
	typedef logic [7:0] aifs_status_t;

	// One bit per channel.
	typedef logic [5:0] aifs_chmask_t;

endpackage : aifs_pkg

// ===== design/aifs_chan_if.sv
`timescale 1ns/1ps
`default_nettype none

// Channel-level conditions handed from the top to the summary logic.
interface aifs_chan_if;
	aifs_pkg::aifs_chmask_t below;
	aifs_pkg::aifs_chmask_t above;
	aifs_pkg::aifs_chmask_t cal_err;
	aifs_pkg::aifs_chmask_t cal_busy;
	logic comm_fault;
	modport src (
		output below,
		output above,
		output cal_err,
		output cal_busy,
		output comm_fault
	);
	modport dst (
		input below,
		input above,
		input cal_err,
		input cal_busy,
		input comm_fault
	);
endinterface : aifs_chan_if

`default_nettype wire

// ===== design/aifs_slope.sv
`timescale 1ns/1ps
`default_nettype none

module aifs_slope (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic sample_valid,
	input wire aifs_pkg::aifs_sample_t [5:0] chan_value,
	input wire aifs_pkg::aifs_word_t [5:0] rate_limit,
	output logic [5:0] rate_over,
	output logic [5:0] rate_under
);

	aifs_pkg::aifs_sample_t [5:0] prev;
	logic have_prev;
	logic [16:0] delta [6];
	logic [16:0] mag [6];

	// Previous sample per channel; the rate is only known after the second sample.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prev <= '0;
			have_prev <= 1'b0;
		end else if (sample_valid) begin
			prev <= chan_value;
			have_prev <= 1'b1;
		end
	end

	// Absolute change per sample, compared both ways against the limit.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			delta[i] = {chan_value[i][15], chan_value[i]} - {prev[i][15], prev[i]};
			mag[i] = delta[i][16] ? 17'(-delta[i]) : delta[i];
			rate_over[i] = have_prev && (mag[i] > {1'b0, rate_limit[i]});
			rate_under[i] = !have_prev || (mag[i] < {1'b0, rate_limit[i]});
		end
	end

endmodule : aifs_slope

`default_nettype wire

// ===== design/aifs_summary.sv
`timescale 1ns/1ps
`default_nettype none
`include "aifs_defines.svh"

module aifs_summary (
	aifs_chan_if.dst chan,
	output aifs_pkg::aifs_word_t next_chan_word,
	output aifs_pkg::aifs_word_t next_mod_word
);

	// Channel word: link loss beats calibration, which beats range faults.
	always_comb begin
		if (chan.comm_fault) begin
			next_chan_word = `AIFS_CF_COMM;
		end else if (|chan.cal_busy) begin
			next_chan_word = `AIFS_CF_CALBUSY;
		end else begin
			next_chan_word = {10'h000, chan.below | chan.above};
		end
	end

	// Module word: only bits 15, 14, 12 and 11 ever carry a condition.
	always_comb begin
		next_mod_word = `AIFS_WORD_RST;
		next_mod_word[`AIFS_MF_ANALOG] = |next_chan_word;
		next_mod_word[`AIFS_MF_INPUT] = |next_chan_word;
		next_mod_word[`AIFS_MF_CALBUSY] = |chan.cal_busy;
		next_mod_word[`AIFS_MF_CALFAULT] = |chan.cal_err;
	end

endmodule : aifs_summary

`default_nettype wire

// ===== design/aifs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aifs_defines.svh"

// What this block does
// - Range flag sets channel fault bit (float).
// - Any calibration error sets module bit 11.
// - Failed calibration sets status bit 7.
// - At or below minimum sets bit 6.
// - At or above maximum sets bit 5.
// - Rate above limit sets bit 4.
// - Low limit alarm bit 3, deadband, latch.
// - High limit alarm bit 2, deadband, latch.
// - Low-low alarm bit 1, deadband, latch.
// - High-high alarm bit 0, deadband, latch.
// - Any channel fault sets bit 15.
// - Calibrating sets bit 12, channel word 003F unless link failed.
// - Link failure makes channel word FFFF.
// - Module bits 13, 10, 9, 8 unused.
// - Integer mode keeps module bits 15-8.
// - Integer mode: one shared range word.
// - Integer mode still reports calibration fault.
// - Integer below-range at bit 15 minus 2n.
// - Integer above-range at bit 14 minus 2n.
// - Alarm flags never reach summary words.
module aifs_top (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic float_mode,
	input wire logic sample_valid,
	input wire aifs_pkg::aifs_sample_t [5:0] chan_value,
	input wire aifs_pkg::aifs_sample_t [5:0] range_min,
	input wire aifs_pkg::aifs_sample_t [5:0] range_max,
	input wire aifs_pkg::aifs_sample_t [5:0] low_limit,
	input wire aifs_pkg::aifs_sample_t [5:0] high_limit,
	input wire aifs_pkg::aifs_sample_t [5:0] low_low_limit,
	input wire aifs_pkg::aifs_sample_t [5:0] high_high_limit,
	input wire aifs_pkg::aifs_sample_t [5:0] deadband,
	input wire aifs_pkg::aifs_word_t [5:0] rate_limit,
	input wire logic [5:0] latch_enable,
	input wire logic [5:0] unlatch,
	input wire logic [5:0] cal_active,
	input wire logic [5:0] cal_done,
	input wire logic [5:0] cal_bad,
	input wire logic comm_fault,
	output aifs_pkg::aifs_word_t module_fault_summary_word,
	output aifs_pkg::aifs_word_t channel_fault_summary_word,
	output aifs_pkg::aifs_status_t [5:0] per_channel_status_word,
	output aifs_pkg::aifs_word_t shared_range_status_word,
	output logic words_valid
);

	logic [5:0] below_range_flag;
	logic [5:0] above_range_flag;
	logic [5:0] slope_alarm_flag;
	logic [5:0] low_limit_alarm_flag;
	logic [5:0] high_limit_alarm_flag;
	logic [5:0] low_low_limit_alarm_flag;
	logic [5:0] high_high_limit_alarm_flag;
	logic [5:0] cal_error_flag;
	logic [5:0] rate_over;
	logic [5:0] rate_under;
	logic flags_fresh;
	aifs_pkg::aifs_word_t next_chan_word;
	aifs_pkg::aifs_word_t next_mod_word;
	aifs_pkg::aifs_status_t [5:0] next_status;
	aifs_pkg::aifs_word_t next_shared;

	aifs_chan_if chan ();

	// Sign-extended sum and difference so limit plus deadband cannot wrap.
	function automatic logic signed [16:0] aifs_add(
		input aifs_pkg::aifs_sample_t a,
		input aifs_pkg::aifs_sample_t b
	);
		aifs_add = 17'($signed({a[15], a}) + $signed({b[15], b}));
	endfunction : aifs_add

	function automatic logic signed [16:0] aifs_sub(
		input aifs_pkg::aifs_sample_t a,
		input aifs_pkg::aifs_sample_t b
	);
		aifs_sub = 17'($signed({a[15], a}) - $signed({b[15], b}));
	endfunction : aifs_sub

	// Alarm hold: a set condition always wins; otherwise a latched alarm
	// waits for an unlatch and an unlatched one for its clear condition.
	function automatic logic aifs_hold(
		input logic cur,
		input logic set,
		input logic clr,
		input logic latched,
		input logic unl
	);
		if (set) begin
			aifs_hold = 1'b1;
		end else if (latched) begin
			aifs_hold = cur && !unl;
		end else begin
			aifs_hold = cur && !clr;
		end
	endfunction : aifs_hold

	// Rate of change per channel against the configured limit.
	aifs_slope u_slope (
		.clock(clock),
		.rst_b(rst_b),
		.sample_valid(sample_valid),
		.chan_value(chan_value),
		.rate_limit(rate_limit),
		.rate_over(rate_over),
		.rate_under(rate_under)
	);

	// Range flags follow the input level on each sample.
	// Equality counts as out of range on both sides.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			below_range_flag <= '0;
			above_range_flag <= '0;
		end else if (sample_valid) begin
			for (int i = 0; i < 6; i++) begin
				below_range_flag[i] <= $signed(chan_value[i]) <= $signed(range_min[i]);
				above_range_flag[i] <= $signed(chan_value[i]) >= $signed(range_max[i]);
			end
		end
	end

	// Unlatched, the slope alarm clears once the change drops below the limit; latched, on an unlatch.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slope_alarm_flag <= '0;
		end else if (sample_valid) begin
			for (int i = 0; i < 6; i++) begin
				slope_alarm_flag[i] <= aifs_hold(slope_alarm_flag[i], rate_over[i],
					rate_under[i], latch_enable[i], unlatch[i]);
			end
		end else begin
			for (int i = 0; i < 6; i++) begin
				slope_alarm_flag[i] <= slope_alarm_flag[i] && !(latch_enable[i] && unlatch[i]
					&& !rate_over[i]);
			end
		end
	end

	// Low side alarms clear above limit plus deadband, or on an unlatch when latched.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			low_limit_alarm_flag <= '0;
			low_low_limit_alarm_flag <= '0;
		end else if (sample_valid) begin
			for (int i = 0; i < 6; i++) begin
				low_limit_alarm_flag[i] <= aifs_hold(low_limit_alarm_flag[i],
					$signed(chan_value[i]) < $signed(low_limit[i]),
					aifs_add(chan_value[i], 16'sh0000) > aifs_add(low_limit[i], deadband[i]),
					latch_enable[i], unlatch[i]);
				low_low_limit_alarm_flag[i] <= aifs_hold(low_low_limit_alarm_flag[i],
					$signed(chan_value[i]) < $signed(low_low_limit[i]),
					aifs_add(chan_value[i], 16'sh0000) > aifs_add(low_low_limit[i], deadband[i]),
					latch_enable[i], unlatch[i]);
			end
		end else begin
			// Between samples only an unlatch can act.
			for (int i = 0; i < 6; i++) begin
				if (latch_enable[i] && unlatch[i]) begin
					low_limit_alarm_flag[i] <= 1'b0;
					low_low_limit_alarm_flag[i] <= 1'b0;
				end
			end
		end
	end

	// High side alarms clear below limit minus deadband, or on an unlatch when latched.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			high_limit_alarm_flag <= '0;
			high_high_limit_alarm_flag <= '0;
		end else if (sample_valid) begin
			for (int i = 0; i < 6; i++) begin
				high_limit_alarm_flag[i] <= aifs_hold(high_limit_alarm_flag[i],
					$signed(chan_value[i]) > $signed(high_limit[i]),
					aifs_add(chan_value[i], 16'sh0000) < aifs_sub(high_limit[i], deadband[i]),
					latch_enable[i], unlatch[i]);
				high_high_limit_alarm_flag[i] <= aifs_hold(high_high_limit_alarm_flag[i],
					$signed(chan_value[i]) > $signed(high_high_limit[i]),
					aifs_add(chan_value[i], 16'sh0000) < aifs_sub(high_high_limit[i], deadband[i]),
					latch_enable[i], unlatch[i]);
			end
		end else begin
			// Between samples only an unlatch can act.
			for (int i = 0; i < 6; i++) begin
				if (latch_enable[i] && unlatch[i]) begin
					high_limit_alarm_flag[i] <= 1'b0;
					high_high_limit_alarm_flag[i] <= 1'b0;
				end
			end
		end
	end

	// Calibration result: a bad finish sets the flag, a good one clears it.
	// A finish with no sample pending still updates the flag at once.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cal_error_flag <= '0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (cal_done[i]) begin
					cal_error_flag[i] <= cal_bad[i];
				end
			end
		end
	end

	// Words are rebuilt one cycle after a sample, once all flags have settled.
	// Loading from the registered flags rather than the raw comparisons keeps
	// all four words from one sample even when samples arrive back to back.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			flags_fresh <= 1'b0;
		end else begin
			flags_fresh <= sample_valid;
		end
	end

	// Only range, calibration and link conditions reach the summary logic.
	assign chan.below = below_range_flag;
	assign chan.above = above_range_flag;
	assign chan.cal_err = cal_error_flag;
	assign chan.cal_busy = cal_active;
	assign chan.comm_fault = comm_fault;

	// Channel and module fault words, shared by both data formats.
	aifs_summary u_summary (
		.chan(chan.dst),
		.next_chan_word(next_chan_word),
		.next_mod_word(next_mod_word)
	);

	// Per-channel status words exist only in floating point mode.
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			next_status[i] = `AIFS_STAT_RST;
			if (float_mode) begin
				next_status[i][`AIFS_SB_CAL] = cal_error_flag[i];
				next_status[i][`AIFS_SB_BELOW] = below_range_flag[i];
				next_status[i][`AIFS_SB_ABOVE] = above_range_flag[i];
				next_status[i][`AIFS_SB_SLOPE] = slope_alarm_flag[i];
				next_status[i][`AIFS_SB_LO] = low_limit_alarm_flag[i];
				next_status[i][`AIFS_SB_HI] = high_limit_alarm_flag[i];
				next_status[i][`AIFS_SB_LL] = low_low_limit_alarm_flag[i];
				next_status[i][`AIFS_SB_HH] = high_high_limit_alarm_flag[i];
			end
		end
	end

	// Integer mode packs two range bits per channel, channel 0 on top.
	always_comb begin
		next_shared = `AIFS_WORD_RST;
		if (!float_mode) begin
			for (int i = 0; i < 6; i++) begin
				next_shared[`AIFS_IR_BELOW_TOP - 2 * i] = below_range_flag[i];
				next_shared[`AIFS_IR_ABOVE_TOP - 2 * i] = above_range_flag[i];
			end
		end
	end

	// All produced words load in the same cycle so they always agree.
	// Mode, calibration and link inputs are taken at this load edge.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			channel_fault_summary_word <= `AIFS_WORD_RST;
			module_fault_summary_word <= `AIFS_WORD_RST;
			per_channel_status_word <= '0;
			shared_range_status_word <= `AIFS_WORD_RST;
		end else if (flags_fresh) begin
			channel_fault_summary_word <= next_chan_word;
			module_fault_summary_word <= next_mod_word;
			per_channel_status_word <= next_status;
			shared_range_status_word <= next_shared;
		end
	end

	// The calibration fault summary is built in the summary module from the
	// same flags in both formats, so integer mode still reports a bad channel
	// even though its status word carries no calibration bit. It sits at
	// bit 11; bit 9 stays one of the unused module bits.
	// Nothing in this module reads that bit back.

	// One-cycle strobe marking fresh words.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			words_valid <= 1'b0;
		end else begin
			words_valid <= flags_fresh;
		end
	end

endmodule : aifs_top

`default_nettype wire

// ===== verification/aifs_properties.sv
`timescale 1ns/1ps
`default_nettype none

module aifs_properties (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic float_mode,
	input wire logic sample_valid,
	input wire logic [5:0] cal_active,
	input wire logic comm_fault,
	input wire aifs_pkg::aifs_word_t module_fault_summary_word,
	input wire aifs_pkg::aifs_word_t channel_fault_summary_word,
	input wire aifs_pkg::aifs_status_t [5:0] per_channel_status_word,
	input wire aifs_pkg::aifs_word_t shared_range_status_word,
	input wire logic words_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [15:0] mw;
	logic [15:0] cw;
	logic [5:0] f_mask;
	logic [5:0] i_mask;
	logic cal_any;
	// Short names for the two summary words.
	assign mw = module_fault_summary_word;
	assign cw = channel_fault_summary_word;
	// Rebuilds the expected summaries from the range and calibration flags.
	always_comb begin
		cal_any = 1'b0;
		for (int n = 0; n < 6; n++) begin
			f_mask[n] = per_channel_status_word[n][6] | per_channel_status_word[n][5];
			i_mask[n] = shared_range_status_word[15 - 2 * n] | shared_range_status_word[14 - 2 * n];
			cal_any = cal_any | per_channel_status_word[n][7];
		end
	end
	sequence s_plain;
		words_valid && !$past(comm_fault) && $past(cal_active) == 6'h00;
	endsequence
	sequence s_calbusy;
		words_valid && !$past(comm_fault) && $past(cal_active) != 6'h00;
	endsequence
	chk_load_latency: assert property (sample_valid |-> ##2 words_valid)
		else $error("words not loaded two edges after a sample");
	chk_load_cause: assert property (words_valid |-> $past(sample_valid, 2))
		else $error("words loaded without a sample");
	chk_words_hold: assert property (!words_valid |-> $stable(mw) && $stable(cw))
		else $error("summary words changed outside a load");
	chk_comm_ones: assert property (words_valid && $past(comm_fault) |-> cw == 16'hFFFF)
		else $error("channel word not all ones on link failure");
	chk_cal_force: assert property (s_calbusy |-> cw == 16'h003F && mw[12])
		else $error("calibration did not force the channel word");
	chk_busy_bit: assert property (words_valid |-> mw[12] == ($past(cal_active) != 6'h00))
		else $error("calibrating bit wrong");
	chk_group_bits: assert property (words_valid |-> mw[15:14] == {2{cw != 16'h0000}})
		else $error("group summary bits wrong");
	chk_unused_bits: assert property (mw[13] == 1'h0 && mw[10:0] == 11'h000)
		else $error("unused module bits set");
	chk_cal_mirror: assert property (words_valid && $past(float_mode) |-> mw[11] == cal_any)
		else $error("calibration fault summary does not match the flags");
	chk_float_faults: assert property (s_plain ##0 $past(float_mode)
		|-> cw == {10'h000, f_mask} && shared_range_status_word == 16'h0000)
		else $error("floating point channel word wrong");
	chk_int_faults: assert property (s_plain ##0 !$past(float_mode)
		|-> cw == {10'h000, i_mask}
		&& per_channel_status_word == '0 && shared_range_status_word[3:0] == 4'h0)
		else $error("integer channel word wrong");
endmodule : aifs_properties

bind aifs_top aifs_properties chk (.clock(clock), .rst_b(rst_b), .float_mode(float_mode),
	.sample_valid(sample_valid), .cal_active(cal_active), .comm_fault(comm_fault),
	.module_fault_summary_word(module_fault_summary_word),
	.channel_fault_summary_word(channel_fault_summary_word),
	.per_channel_status_word(per_channel_status_word),
	.shared_range_status_word(shared_range_status_word), .words_valid(words_valid));

`default_nettype wire

// ===== verification/aifs_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module aifs_ctl_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic link_lost,
	input wire logic words_valid,
	input wire aifs_pkg::aifs_word_t mod_word,
	input wire aifs_pkg::aifs_word_t chan_word,
	output logic comm_fault,
	output aifs_pkg::aifs_word_t seen_mod,
	output aifs_pkg::aifs_word_t seen_chan
);
	// A lost link is reported to the module as a level.
	assign comm_fault = link_lost;
	// Both summaries are taken at one load so they always form a matched pair.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			seen_mod <= 16'h0000;
			seen_chan <= 16'h0000;
		end else if (words_valid) begin
			seen_mod <= mod_word;
			seen_chan <= chan_word;
		end
	end
endmodule : aifs_ctl_model

`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clock;
	logic rst_b;
	logic fm;
	logic sv;
	logic link_lost;
	logic cf;
	logic wv;
	logic [5:0] le;
	logic [5:0] ul;
	logic [5:0] ca;
	logic [5:0] cd;
	logic [5:0] cb;
	aifs_pkg::aifs_sample_t [5:0] cv;
	aifs_pkg::aifs_sample_t [5:0] lo;
	aifs_pkg::aifs_sample_t [5:0] hi;
	aifs_pkg::aifs_word_t [5:0] rl;
	aifs_pkg::aifs_status_t [5:0] st;
	aifs_pkg::aifs_word_t mw;
	aifs_pkg::aifs_word_t cw;
	aifs_pkg::aifs_word_t sw;
	aifs_pkg::aifs_word_t smw;
	aifs_pkg::aifs_word_t scw;
	int err_total;
	int comparisons;

	aifs_top dut (.clock(clock), .rst_b(rst_b), .float_mode(fm), .sample_valid(sv),
		.chan_value(cv), .range_min({6{16'hFC18}}), .range_max({6{16'h03E8}}),
		.low_limit(lo), .high_limit(hi), .low_low_limit({6{16'hFCE0}}),
		.high_high_limit({6{16'h0320}}), .deadband({6{16'h000A}}), .rate_limit(rl),
		.latch_enable(le), .unlatch(ul), .cal_active(ca), .cal_done(cd), .cal_bad(cb),
		.comm_fault(cf), .module_fault_summary_word(mw), .channel_fault_summary_word(cw),
		.per_channel_status_word(st), .shared_range_status_word(sw), .words_valid(wv));

	aifs_ctl_model ctl (.clock(clock), .rst_b(rst_b), .link_lost(link_lost), .words_valid(wv),
		.mod_word(mw), .chan_word(cw), .comm_fault(cf), .seen_mod(smw), .seen_chan(scw));

	// Free-running clock of 100 ns.
	always #50 clock = ~clock;

	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Gives the verdict and ends the run.
	task automatic wrap_up;
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	// One sample, then waits until the controller has taken the words.
	task automatic smp;
		sv = 1'b1;
		@(posedge clock);
		#1 sv = 1'b0;
		@(posedge clock);
		#1 chk({15'h0000, wv}, 16'h0001);
		@(posedge clock);
		#1;
	endtask : smp

	// Range edges exactly at the limits, with alarms that must stay local.
	task automatic t_range_float;
		fm = 1'b1;
		cv = {16'h0000, 16'h0000, 16'h0258, 16'hFDA8, 16'h03E8, 16'hFC18};
		smp();
		chk({8'h00, st[0]}, 16'h004A);
		chk({8'h00, st[1]}, 16'h0025);
		chk({8'h00, st[2]}, 16'h0008);
		chk({8'h00, st[3]}, 16'h0004);
		chk(scw, 16'h0003);
		chk(smw, 16'hC000);
		chk(sw, 16'h0000);
	endtask : t_range_float

	// The same inputs in integer format, last channel over range too.
	task automatic t_range_int;
		fm = 1'b0;
		cv[5] = 16'h03E8;
		smp();
		chk(sw, 16'h9010);
		chk({st[1], st[0]}, 16'h0000);
		chk(scw, 16'h0023);
		chk(smw, 16'hC000);
		cv[5] = 16'h0000;
	endtask : t_range_int

	// Deadband hold, slope set and clear, then a latched alarm and its release.
	task automatic t_alarms;
		fm = 1'b1;
		cv[0] = 16'h0000;
		cv[1] = 16'h0000;
		cv[2] = 16'hFE11;
		cv[4] = 16'h00C8;
		smp();
		chk({8'h00, st[2]}, 16'h0008);
		chk({8'h00, st[4]}, 16'h0010);
		chk({st[1], st[0]}, 16'h0000);
		cv[2] = 16'hFE20;
		cv[4] = 16'h00FA;
		smp();
		chk({st[4], st[2]}, 16'h0000);
		le[2] = 1'b1;
		cv[2] = 16'hFDA8;
		smp();
		cv[2] = 16'hFE20;
		smp();
		chk({8'h00, st[2]}, 16'h0008);
		ul[2] = 1'b1;
		smp();
		ul[2] = 1'b0;
		chk({8'h00, st[2]}, 16'h0000);
	endtask : t_alarms

	// Bad calibration, calibration in progress, then a lost link.
	task automatic t_cal;
		cd[5] = 1'b1;
		cb[5] = 1'b1;
		@(posedge clock);
		#1 cd = 6'h00;
		cb = 6'h00;
		smp();
		chk({8'h00, st[5]}, 16'h0080);
		chk(smw, 16'h0800);
		fm = 1'b0;
		smp();
		chk(smw, 16'h0800);
		chk({8'h00, st[5]}, 16'h0000);
		ca[1] = 1'b1;
		smp();
		chk(scw, 16'h003F);
		chk(smw, 16'hD800);
		link_lost = 1'b1;
		smp();
		chk(scw, 16'hFFFF);
		chk(smw, 16'hD800);
	endtask : t_cal

	// Reset, then the scenarios in turn.
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		fm = 1'b1;
		sv = 1'b0;
		link_lost = 1'b0;
		le = 6'h00;
		ul = 6'h00;
		ca = 6'h00;
		cd = 6'h00;
		cb = 6'h00;
		cv = '0;
		lo = {6{16'hFE0C}};
		hi = {6{16'h01F4}};
		rl = {16'hFFFF, 16'h0064, {4{16'hFFFF}}};
		err_total = 0;
		comparisons = 0;
		repeat (8) @(posedge clock);
		#1 rst_b = 1'b1;
		chk(mw | cw | sw | {15'h0000, wv}, 16'h0000);
		t_range_float();
		t_range_int();
		t_alarms();
		t_cal();
		wrap_up();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#2000000;
		err_total++;
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
